//--- hw/deep_sleep_defines.svh
// Constants for the deep sleep mode controller
`ifndef DEEP_SLEEP_DEFINES_SVH
`define DEEP_SLEEP_DEFINES_SVH
`define SLEEP_OPCODE        8'h8e
`define PRIO_FORCED         2'h2
`define PRIO_RESET          2'h3
`define STAB_SHORT_CYCLES   13'h0100
`define STAB_LONG_CYCLES    13'h1000
`define STAB_CNT_W          13
`endif

//--- hw/deep_sleep_pkg.sv
// Types for the deep sleep mode controller
`default_nettype none
package deep_sleep_pkg;
    // Sleep controller states, Gray in declaration order
    typedef enum logic [2:0] {
        st_run     = 3'b000,
        st_timed   = 3'b001,
        st_halt    = 3'b011,
        st_stab    = 3'b010,
        st_resume  = 3'b110
    } sleep_state_t;

    // Clock gating outputs travel together
    typedef struct packed {
        logic osc_on;
        logic cpu_clk_en;
        logic rtc_clk_en;
        logic periph_clk_en;
    } clk_gate_t;

    // Wake sources
    typedef struct packed {
        logic rtc_irq;
        logic ext_irq;
        logic any_pending;
    } wake_src_t;
endpackage : deep_sleep_pkg
`default_nettype wire

//--- hw/stab_counter.sv
// Oscillator stabilisation down-counter
`default_nettype none
`include "deep_sleep_defines.svh"
module stab_counter
    import deep_sleep_pkg::*;
#(
    parameter logic [`STAB_CNT_W-1:0] SHORT_COUNT = `STAB_SHORT_CYCLES,
    parameter logic [`STAB_CNT_W-1:0] LONG_COUNT  = `STAB_LONG_CYCLES
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic load,        // Restart pulse
    input  wire logic long_sel,    // Use the long count
    input  wire logic run,         // Oscillator running
    output var  logic [`STAB_CNT_W-1:0] remaining,
    output var  logic done         // One-cycle pulse at expiry
);
    // ****************************************
    // Down-counter on the restarted oscillator
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            remaining <= '0;
            done      <= 1'b0;
        end else if (load) begin
            remaining <= long_sel ? LONG_COUNT : SHORT_COUNT;
            done      <= 1'b0;
        end else if (run && remaining != '0) begin
            remaining <= remaining - 1'b1;
            done      <= (remaining == `STAB_CNT_W'(1));
        end else begin
            done      <= 1'b0;
        end
    end
endmodule : stab_counter
`default_nettype wire

//--- hw/deep_sleep_mode_control.sv
// Deep sleep mode controller: timed deep sleep and full-stop halt
//
// Contract
// - Sleep opcode picks timed or halt by enable
// - Timed sleep exits on rtc, wake irq, reset
// - Interrupt exit from timed sleep skips delay
// - Reset exit from timed sleep waits delay
// - Entry forces priority 10b; pending wakes
// - Timed sleep runs oscillator and rtc only
// - Timed sleep with rtc irq: no watchdog reset
// - Early enable clear halts for remaining delay
// - Halt exits on wake irq or reset only
// - Halt exit restarts oscillator then waits delay
// - Halt stops oscillator and all peripherals
// - Watchdog halt option decides watchdog reset
// - Wake service pushes flags, sets priority
// - Opcode 8e decodes as sleep
`default_nettype none
`include "deep_sleep_defines.svh"
module deep_sleep_mode_control
    import deep_sleep_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       opcode_valid,     // Decoded opcode strobe
    input  wire logic [7:0] opcode,           // Opcode being executed
    input  wire logic       rtc_irq_enable,   // Clock-unit interrupt enable
    input  wire logic       rtc_irq,          // Clock-unit interrupt request
    input  wire logic       ext_wake_irq,     // Wake-capable interrupt, async
    input  wire logic       irq_pending,      // Any interrupt pending
    input  wire logic       wake_reset_req,   // Reset request while asleep
    input  wire logic       watchdog_enabled, // Watchdog running
    input  wire logic       watchdog_halt_option, // Static option bit
    input  wire logic       long_delay_opt,   // Static delay option
    input  wire logic       irq_ack,          // Core takes an interrupt
    input  wire logic       iret_pop,         // Core pops flags
    input  wire logic [1:0] irq_sw_prio,      // Routine priority level
    input  wire logic [7:0] cc_in,            // Current flags
    input  wire logic [7:0] cc_popped,        // Flags from stack
    output var  logic       osc_on,           // Main oscillator enable
    output var  logic       cpu_clk_en,       // CPU clock gate
    output var  logic       rtc_clk_en,       // Clock-unit counter gate
    output var  logic       periph_clk_en,    // Other peripheral gate
    output var  logic       in_timed_sleep,   // Status: timed sleep
    output var  logic       in_halt,          // Status: full-stop halt
    output var  logic       watchdog_reset,   // Pulse: watchdog reset
    output var  logic       wake_service,     // Pulse: service waking irq
    output var  logic       fetch_reset_vec,  // Pulse: fetch reset vector
    output var  logic       cc_push,          // Pulse: push flags
    output var  logic [7:0] cc_push_data,     // Flags to push
    output var  logic [1:0] interrupt_priority_bits // Priority field
);
    // ****************************************
    // Signals
    // ****************************************
    sleep_state_t state;                      // Controller state
    logic         ext_meta;                   // Sync stage one
    logic         ext_sync;                   // Sync stage two
    logic         long_sel;                   // Option caught at reset
    logic         stab_load;                  // Start the count
    logic         stab_done;                  // Count expired
    logic [`STAB_CNT_W-1:0] stab_left;       // Cycles remaining
    logic         wake_by_reset;              // Cause of current delay
    logic         post_wake;                  // Window after timed wake
    logic         stab_osc_run;               // Oscillator feeding counter
    logic         is_sleep;                   // Sleep opcode seen
    wake_src_t    wake;                       // Collected wake sources

    // Decode a sleep opcode
    function automatic logic sleep_decode(input logic v, input logic [7:0] op);
        return v && (op == `SLEEP_OPCODE);
    endfunction : sleep_decode

    // Sleep is only taken from a valid opcode strobe
    // A stray 8e byte in data would stop the core
    assign is_sleep = sleep_decode(opcode_valid, opcode);
    // Wake sources gathered for the state machine
    // Clock-unit irq only counts in timed sleep
    assign wake     = '{rtc_irq: rtc_irq, ext_irq: ext_sync, any_pending: irq_pending};

    // ****************************************
    // Synchroniser for the external wake line
    // ****************************************
    // Wake pin is asynchronous to the master clock
    // Two flops before any decision logic
    // Adds two cycles of wake latency
    // Only the second flop is read downstream
    always_ff @(posedge clock) begin
        if (srst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end else begin
            ext_meta <= ext_wake_irq;
            ext_sync <= ext_meta;
        end
    end

    // ****************************************
    // Delay option caught while reset is held
    // ****************************************
    // Static option, frozen when reset lets go
    // Later changes on the pin are ignored
    // Keeps one delay length for the whole run
    always_ff @(posedge clock) begin
        if (srst) begin
            long_sel <= long_delay_opt;
        end
    end

    // ****************************************
    // Stabilisation counter
    // ****************************************
    // Loaded on every oscillator restart
    // Also runs after a timed-sleep interrupt wake
    // That span guards the enable-clear hazard
    // Done pulse marks the end of the delay
    stab_counter u_stab (
        .clock     (clock),
        .srst      (srst),
        .load      (stab_load),
        .long_sel  (long_sel),
        .run       (stab_osc_run),
        .remaining (stab_left),
        .done      (stab_done)
    );

    // Counter sees oscillator only while it runs
    assign stab_osc_run = (state == st_stab) || post_wake;

    // ****************************************
    // Main sleep state machine
    // ****************************************
    // Run: core clocked, waiting for sleep opcode
    // Timed: oscillator and clock unit alive
    // Halt: oscillator stopped, rtc cannot wake
    // Stab: oscillator back, counting the delay
    // Resume: one cycle to hand back to the core
    //
    // Interrupt wake from timed sleep skips stab
    // Reset wake from timed sleep goes through stab
    // Any wake from halt goes through stab
    // Clearing the enable early re-enters stab
    //
    // Watchdog may turn a halt into a reset
    // Pulses are cleared at every edge by default
    // Only one sleep request is in flight
    always_ff @(posedge clock) begin
        if (srst) begin
            state           <= st_run;
            stab_load       <= 1'b0;
            wake_by_reset   <= 1'b0;
            post_wake       <= 1'b0;
            watchdog_reset  <= 1'b0;
            wake_service    <= 1'b0;
            fetch_reset_vec <= 1'b0;
        end else begin
            stab_load       <= 1'b0;
            watchdog_reset  <= 1'b0;
            wake_service    <= 1'b0;
            fetch_reset_vec <= 1'b0;
            if (stab_done) begin
                post_wake <= 1'b0;
            end
            case (state)
                // Running: wait for a sleep opcode
                st_run: begin
                    if (is_sleep) begin
                        if (rtc_irq_enable) begin
                            state <= st_timed;
                        end else if (watchdog_enabled && !watchdog_halt_option) begin
                            watchdog_reset <= 1'b1;
                        end else begin
                            state <= st_halt;
                        end
                    end else if (post_wake && !rtc_irq_enable) begin
                        state <= st_stab;
                        wake_by_reset <= 1'b0;
                    end
                end
                // Timed sleep: oscillator and clock unit alive
                st_timed: begin
                    if (wake_reset_req) begin
                        state         <= st_stab;
                        wake_by_reset <= 1'b1;
                        stab_load     <= 1'b1;
                    end else if (wake.rtc_irq || wake.ext_irq || wake.any_pending) begin
                        state        <= st_resume;
                        wake_service <= 1'b1;
                        post_wake    <= 1'b1;
                        stab_load    <= 1'b1;
                    end
                end
                // Halt: oscillator off, rtc cannot wake
                st_halt: begin
                    if (wake_reset_req || wake.ext_irq || wake.any_pending) begin
                        state         <= st_stab;
                        wake_by_reset <= wake_reset_req;
                        stab_load     <= 1'b1;
                    end
                end
                // Oscillator back on, waiting the count
                st_stab: begin
                    if (stab_done || (stab_left == '0 && !stab_load)) begin
                        state           <= st_resume;
                        fetch_reset_vec <= wake_by_reset;
                        wake_service    <= !wake_by_reset && !post_wake;
                    end
                end
                // One cycle to hand back to the core
                st_resume: begin
                    state <= st_run;
                end
                default: begin
                    state <= st_run;
                end
            endcase
        end
    end

    // ****************************************
    // Clock gating per state
    // ****************************************
    // Gates follow the state one edge later
    // Oscillator off only in true halt
    // Clock unit stops in halt and during stab
    // Core and peripherals run only in run/resume
    // Separately clocked peripherals are not ours
    // Reset leaves every clock running
    always_ff @(posedge clock) begin
        if (srst) begin
            osc_on        <= 1'b1;
            cpu_clk_en    <= 1'b1;
            rtc_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
        end else begin
            osc_on        <= !(state == st_halt);
            cpu_clk_en    <= (state == st_run) || (state == st_resume);
            rtc_clk_en    <= (state != st_halt) && (state != st_stab);
            periph_clk_en <= (state == st_run) || (state == st_resume);
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // Halt flag also covers the delay count
    // Both flags low while the core runs
    // Registered so they leave straight from flops
    always_ff @(posedge clock) begin
        if (srst) begin
            in_timed_sleep <= 1'b0;
            in_halt        <= 1'b0;
        end else begin
            in_timed_sleep <= (state == st_timed);
            in_halt        <= (state == st_halt) || (state == st_stab);
        end
    end

    // ****************************************
    // Priority bits and flag push
    // ****************************************
    // Sleep entry forces level 10b to unmask
    // Not forced when the watchdog resets instead
    // Interrupt take pushes flags, loads level
    // Return restores level from popped flags
    // Level sits in bits 5 and 3 of the flags
    // Sleep entry wins over a same-cycle take
    always_ff @(posedge clock) begin
        if (srst) begin
            interrupt_priority_bits <= `PRIO_RESET;
            cc_push                 <= 1'b0;
            cc_push_data            <= 8'h00;
        end else begin
            cc_push <= 1'b0;
            if (state == st_run && is_sleep && (rtc_irq_enable || watchdog_halt_option
                    || !watchdog_enabled)) begin
                interrupt_priority_bits <= `PRIO_FORCED;
            end else if (irq_ack) begin
                cc_push                 <= 1'b1;
                cc_push_data            <= cc_in;
                interrupt_priority_bits <= irq_sw_prio;
            end else if (iret_pop) begin
                interrupt_priority_bits <= cc_popped[5] ? {cc_popped[5], cc_popped[3]}
                                                        : {1'b0, cc_popped[3]};
            end
        end
    end
endmodule : deep_sleep_mode_control
`default_nettype wire

//--- test/deep_sleep_mode_control_properties.sv
// Concurrent checks on the deep sleep mode controller ports
`default_nettype none
`include "deep_sleep_defines.svh"
module dsm_props (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       opcode_valid,
    input wire logic [7:0] opcode,
    input wire logic       rtc_irq_enable,
    input wire logic       rtc_irq,
    input wire logic       irq_pending,
    input wire logic       watchdog_enabled,
    input wire logic       watchdog_halt_option,
    input wire logic       long_delay_opt,
    input wire logic       iret_pop,
    input wire logic [7:0] cc_popped,
    input wire logic       osc_on,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       in_timed_sleep,
    input wire logic       in_halt,
    input wire logic       watchdog_reset,
    input wire logic       wake_service,
    input wire logic       fetch_reset_vec,
    input wire logic [1:0] interrupt_priority_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Helper logic
    // ****************************************
    localparam int SHORT_MIN = 250;  // Short count less pipeline slack
    localparam int LONG_MIN  = 4090; // Long count less pipeline slack
    logic        long_sel;  // Delay option held from reset
    logic [12:0] stab_cnt;  // Cycles with oscillator on, core stopped
    logic        go;        // Sleep opcode taken while running
    logic        wdg_bar;   // Sleep that the watchdog turns into a reset
    assign go = opcode_valid && opcode == `SLEEP_OPCODE && cpu_clk_en && !wake_service
                && !irq_pending;
    assign wdg_bar = !rtc_irq_enable && watchdog_enabled && !watchdog_halt_option;
    // Option capture during reset
    always_ff @(posedge clock) if (srst) long_sel <= long_delay_opt;
    // Stabilisation span counter, saturating
    always_ff @(posedge clock) begin
        if (srst || !osc_on || cpu_clk_en || in_timed_sleep) stab_cnt <= 13'h0;
        else if (stab_cnt != 13'h1fff) stab_cnt <= stab_cnt + 13'h1;
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking dcb @(posedge clock); endclocking
    default disable iff (srst);
    entry_prio_a: assert property (
        go && !wdg_bar |=> interrupt_priority_bits == `PRIO_FORCED)
        else $error("Priority not forced");
    timed_entry_a: assert property (
        go && rtc_irq_enable |-> ##2 (in_timed_sleep && osc_on && !cpu_clk_en && !periph_clk_en))
        else $error("Timed sleep not entered");
    halt_entry_a: assert property (
        go && !rtc_irq_enable && !wdg_bar
        |-> ##2 (in_halt && !osc_on && !cpu_clk_en && !periph_clk_en))
        else $error("Halt not entered");
    wdg_reset_a: assert property (
        go && wdg_bar |-> ##[1:2] watchdog_reset) else $error("Watchdog reset missing");
    timed_no_wdg_a: assert property (
        in_timed_sleep |-> !watchdog_reset) else $error("Watchdog reset in timed sleep");
    rtc_wake_a: assert property (
        in_timed_sleep && $rose(rtc_irq) |-> ##[1:2] wake_service) else $error("Slow timed wake");
    halt_hold_a: assert property (
        in_halt && rtc_irq && !irq_pending |=> in_halt) else $error("Clock irq left halt");
    wake_delay_a: assert property (
        (wake_service || fetch_reset_vec) && !$past(cpu_clk_en) && !$past(in_timed_sleep)
        |-> stab_cnt >= (long_sel ? LONG_MIN : SHORT_MIN)) else $error("Delay cut short");
    prio_restore_a: assert property (
        iret_pop |=> interrupt_priority_bits == {cc_popped[5], cc_popped[3]})
        else $error("Priority not restored");
endmodule : dsm_props
bind deep_sleep_mode_control dsm_props u_dsm_props (.*);
`default_nettype wire

//--- test/core_side_model.sv
// Core-side model: takes a waking interrupt and returns from it
`default_nettype none
module core_side_model (
    input  wire logic       clock,
    input  wire logic       wake_service,
    output wire logic       irq_ack,
    output wire logic       iret_pop,
    output wire logic [1:0] irq_sw_prio,
    output wire logic [7:0] cc_in,
    output wire logic [7:0] cc_popped
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] dly = 3'h0;  // Steps left in the service routine
    // Routine progress after each wake
    always @(posedge clock) dly <= wake_service ? 3'h5 : ((dly != 3'h0) ? dly - 3'h1 : 3'h0);
    assign irq_ack     = (dly == 3'h5);  // Vector taken
    assign iret_pop    = (dly == 3'h1);  // Flags popped on return
    assign irq_sw_prio = 2'h0;           // Routine level
    assign cc_in       = 8'h28;          // Running flags, level 3
    assign cc_popped   = 8'h08;          // Stacked flags, level 1
endmodule : core_side_model
`default_nettype wire

//--- test/deep_sleep_mode_control_tb.sv
// Self-checking bench for the deep sleep mode controller
`default_nettype none
`include "deep_sleep_defines.svh"
module deep_sleep_mode_control_tb;
    import deep_sleep_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals
    // ****************************************
    logic       clock = 1'b0, srst = 1'b1, opcode_valid = 1'b0, rtc_irq = 1'b0;
    logic       rtc_irq_enable = 1'b0, irq_pending = 1'b0, wake_reset_req = 1'b0;
    logic       ext_wake_irq = 1'b0;  // Wake line idles inactive
    logic       watchdog_enabled = 1'b0, watchdog_halt_option = 1'b0, long_delay_opt = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic       irq_ack, iret_pop, osc_on, cpu_clk_en, rtc_clk_en, periph_clk_en, cc_push;
    logic       in_timed_sleep, in_halt, watchdog_reset, wake_service, fetch_reset_vec;
    logic [1:0] irq_sw_prio, interrupt_priority_bits;
    logic [7:0] cc_in, cc_popped, cc_push_data;
    logic [3:0] pulses;  // Outputs a wait can pick from
    int         err_total = 0;
    int         cmp_count = 0;
    assign pulses = {cpu_clk_en, watchdog_reset, fetch_reset_vec, wake_service};
    deep_sleep_mode_control dut (.*);
    core_side_model core (.*);
    initial forever #4 clock = ~clock;  // 125 MHz
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cycles(input int n);  // Let edges pass, then settle
        repeat (n) @(posedge clock);
        #1;
    endtask : cycles
    task automatic wait_for(input int which, output int n);  // Edges until a pulse
        n = 0;
        do begin
            cycles(1);
            n++;
        end while (pulses[which] !== 1'b1 && n < 5000);
    endtask : wait_for
    task automatic do_reset(input logic long_opt);
        @(posedge clock);
        srst <= 1'b1;
        long_delay_opt <= long_opt;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
    endtask : do_reset
    // Config is {enable, watchdog on, halt option, pending}
    task automatic sleep(input logic [7:0] code, input logic [3:0] cfg);
        @(posedge clock);
        {rtc_irq_enable, watchdog_enabled, watchdog_halt_option, irq_pending} <= cfg;
        opcode_valid <= 1'b1;
        opcode <= code;
        @(posedge clock);
        opcode_valid <= 1'b0;
        opcode <= ~code;
    endtask : sleep
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_opcode;  // Near-miss opcodes leave the core running
        logic [7:0] codes [3] = '{8'h8f, 8'h0e, 8'h9d};
        for (int i = 0; i < 3; i++) begin
            sleep(codes[i], 4'b1000);
            cycles(2);
            chk({in_timed_sleep, cpu_clk_en}, 2'b01);
        end
    endtask : t_opcode
    task automatic t_timed(input logic early);  // Timed sleep, clock-unit wake
        int n;
        sleep(`SLEEP_OPCODE, 4'b1100);
        cycles(2);
        chk({in_timed_sleep, osc_on, rtc_clk_en, cpu_clk_en, periph_clk_en}, 5'b11100);
        chk(interrupt_priority_bits, `PRIO_FORCED);
        cycles(20);
        chk({in_timed_sleep, watchdog_reset}, 2'b10);
        @(posedge clock);
        rtc_irq <= 1'b1;
        wait_for(0, n);
        chk(n <= 3, 1'b1);
        @(posedge clock);
        rtc_irq <= 1'b0;
        cycles(1);
        chk({cc_push, cc_push_data, interrupt_priority_bits}, {1'b1, cc_in, 2'h0});
        cycles(8);
        chk(interrupt_priority_bits, 2'h1);
        @(posedge clock);
        rtc_irq_enable <= !early;  // Enable kept unless the early clear is tried
        cycles(3);
        chk(cpu_clk_en, !early);
        wait_for(3, n);
        chk(n > 230 && n < 260, early);
        cycles(260);
    endtask : t_timed
    task automatic t_pending;  // Pending interrupt wakes at once
        int n;
        sleep(`SLEEP_OPCODE, 4'b1001);
        wait_for(0, n);
        chk(n <= 3, 1'b1);
        @(posedge clock);
        irq_pending <= 1'b0;  // Nothing left pending before the next sleep
        cycles(260);
    endtask : t_pending
    task automatic t_wdg;  // Halt refused by the watchdog
        sleep(`SLEEP_OPCODE, 4'b0100);
        #1;
        chk(watchdog_reset, 1'b1);
        cycles(2);
        chk({in_halt, cpu_clk_en}, 2'b01);
    endtask : t_wdg
    task automatic t_halt(input int cnt);  // Halt, clock irq ignored, external wake
        int n;
        sleep(`SLEEP_OPCODE, 4'b0110);
        cycles(2);
        chk({in_halt, osc_on, cpu_clk_en, periph_clk_en}, 4'b1000);
        @(posedge clock);
        rtc_irq <= 1'b1;
        cycles(5);
        chk(in_halt, 1'b1);
        @(posedge clock);
        rtc_irq <= 1'b0;
        ext_wake_irq <= 1'b1;
        wait_for(0, n);
        chk(n >= cnt && n <= cnt + 10, 1'b1);
        @(posedge clock);
        ext_wake_irq <= 1'b0;
        cycles(12);
    endtask : t_halt
    task automatic t_reset_timed;  // Reset ends timed sleep after the delay
        int n;
        sleep(`SLEEP_OPCODE, 4'b1000);
        cycles(4);
        @(posedge clock);
        wake_reset_req <= 1'b1;
        wait_for(1, n);
        chk(n >= 256 && n <= 266, 1'b1);
        @(posedge clock);
        wake_reset_req <= 1'b0;
        cycles(4);
    endtask : t_reset_timed
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // ****************************************
    // Main sequence and hang guard
    // ****************************************
    initial begin
        do_reset(1'b0);
        t_opcode();
        t_timed(1'b0);
        t_pending();
        t_wdg();
        t_halt(`STAB_SHORT_CYCLES);
        t_reset_timed();
        t_timed(1'b1);
        do_reset(1'b1);
        t_halt(`STAB_LONG_CYCLES);
        stop_test();
    end
    initial begin
        #150us;
        err_total++;
        stop_test();
    end
endmodule : deep_sleep_mode_control_tb
`default_nettype wire
